// >>> inc/irap_params.svh
// offsets, field positions, reset values and timing counts of the access port
`ifndef IRAP_PARAMS_SVH
`define IRAP_PARAMS_SVH

`define IRAP_CLK_PERIOD_NS   50
`define IRAP_ACCESS_TIME_NS  4000
`define IRAP_ACCESS_MAX_CYC  (`IRAP_ACCESS_TIME_NS / `IRAP_CLK_PERIOD_NS)
`define IRAP_ACCESS_CYC      4

`define IRAP_NUM_LINKS       8
`define IRAP_NUM_BLOCKS      3
`define IRAP_DEPTH           128
`define IRAP_IADDR_W         7

`define IRAP_LINK_MSB        10
`define IRAP_LINK_LSB        8
`define IRAP_DIR_BIT         7
`define IRAP_BUSY_BIT        0

`define IRAP_TXP_STATE_OFF   8'hC8
`define IRAP_TXP_CMD_OFF     8'hC9
`define IRAP_TXP_VALUE_OFF   8'hCA
`define IRAP_RXP_STATE_OFF   8'hCD
`define IRAP_RXP_CMD_OFF     8'hCE
`define IRAP_RXP_VALUE_OFF   8'hCF
`define IRAP_RXS_STATE_OFF   8'hD3
`define IRAP_RXS_CMD_OFF     8'hD4
`define IRAP_RXS_VALUE_OFF   8'hD5

`define IRAP_CMD_RESET       8'h00
`define IRAP_VALUE_RESET     8'h00
`define IRAP_RDATA_UNMAPPED  8'h00

`endif

// >>> inc/irap_pkg.sv
// types shared by the indirect register access port
package irap_pkg;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } irap_req_t;

    typedef enum logic [1:0] {
        IRAP_IDLE = 2'b01,
        IRAP_RUN  = 2'b10
    } irap_state_t;

endpackage

// >>> hw/irap_chan.sv
// one state/command/value triplet with its indirect array
`timescale 1ns/10ps
`include "irap_params.svh"

module irap_chan #(
    parameter int LAT_CYC = `IRAP_ACCESS_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // register strobes
    input  wire logic       wr_cmd,
    input  wire logic       wr_value,
    input  wire logic [7:0] wdata,
    // register contents
    output logic            busy_r,
    output logic [7:0]      cmd_r,
    output logic [7:0]      value_r
);
    import irap_pkg::*;

    localparam int MAX_WAIT = `IRAP_ACCESS_MAX_CYC;

    irap_state_t state_r;
    logic [6:0]  cnt_r;
    logic [7:0]  mem [`IRAP_DEPTH];
    logic        done;
    logic        dir_rd;
    logic [`IRAP_IADDR_W-1:0] iaddr;

    assign done   = (state_r == IRAP_RUN) && (cnt_r == 7'(LAT_CYC - 1));
    assign dir_rd = cmd_r[`IRAP_DIR_BIT];
    assign iaddr  = cmd_r[`IRAP_IADDR_W-1:0];

    // sequencer: a command write launches, done ends the access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= IRAP_IDLE;
            busy_r  <= 1'b0;
            cnt_r   <= 7'h00;
        end else begin
            unique case (state_r)
                IRAP_IDLE: begin
                    cnt_r <= 7'h00;
                    if (wr_cmd) begin
                        state_r <= IRAP_RUN;
                        busy_r  <= 1'b1;
                    end
                end
                IRAP_RUN: begin
                    cnt_r <= cnt_r + 7'h01;
                    if (done) begin
                        state_r <= IRAP_IDLE;
                        busy_r  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // command register: direction and indirect address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmd_r <= `IRAP_CMD_RESET;
        end else if (wr_cmd && state_r == IRAP_IDLE) begin
            cmd_r <= wdata;
        end
    end

    // value register: host data, or read result on completion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value_r <= `IRAP_VALUE_RESET;
        end else if (done && dir_rd) begin
            value_r <= mem[iaddr];
        end else if (wr_value && state_r == IRAP_IDLE) begin
            value_r <= wdata;
        end
    end

    // indirect array, reached only from the value register
    always_ff @(posedge clk) begin
        if (done && !dir_rd) begin
            mem[iaddr] <= value_r;
        end
    end

    busy_launch_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr_cmd && state_r == IRAP_IDLE) |=> busy_r
    ) else $error("busy not raised by command write");

    access_bound_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(busy_r) |-> ##[1:MAX_WAIT] !busy_r
    ) else $error("indirect access exceeds time limit");

    read_result_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (done && dir_rd) |=> (value_r == $past(mem[iaddr]))
    ) else $error("read result not in value register");

    write_store_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (done && !dir_rd) |=> (mem[$past(iaddr)] == $past(value_r))
    ) else $error("write value not stored in array");

    idle_busy_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state_r == IRAP_IDLE) |-> !busy_r
    ) else $error("busy set while idle");

    cmd_hold_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        busy_r |=> $stable(cmd_r)
    ) else $error("command changed during access");

    cover_read_c: cover property (
        @(posedge clk) disable iff (sys_rst) done && dir_rd);
    cover_write_c: cover property (
        @(posedge clk) disable iff (sys_rst) done && !dir_rd);

endmodule

// >>> hw/irap_top.sv
// indirect register access port for eight links and three blocks
`timescale 1ns/10ps
`include "irap_params.svh"

// How it works
// - indirect arrays reachable only through triplets
// - completed read result appears in value
// - write command stores value into array
// - every access ends within 4 us
// - command holds direction and 7-bit address
// - value registers are 8 bits wide
// - busy flag readable in state register
// - triplets repeat for eight links
module irap_top #(
    parameter int LAT_CYC = `IRAP_ACCESS_CYC
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    // register port
    input  wire irap_pkg::irap_req_t host_req,
    output logic [7:0]               host_rdata_r
);
    import irap_pkg::*;

    localparam int NB = `IRAP_NUM_BLOCKS;
    localparam int NL = `IRAP_NUM_LINKS;
    localparam int MAX_WAIT = `IRAP_ACCESS_MAX_CYC;
    localparam logic [7:0] STATE_OFF [NB] = '{
        `IRAP_TXP_STATE_OFF, `IRAP_RXP_STATE_OFF, `IRAP_RXS_STATE_OFF};
    localparam logic [7:0] CMD_OFF [NB] = '{
        `IRAP_TXP_CMD_OFF, `IRAP_RXP_CMD_OFF, `IRAP_RXS_CMD_OFF};
    localparam logic [7:0] VALUE_OFF [NB] = '{
        `IRAP_TXP_VALUE_OFF, `IRAP_RXP_VALUE_OFF, `IRAP_RXS_VALUE_OFF};

    logic [2:0]  link;
    logic [7:0]  off;
    logic        busy_w  [NB][NL];
    logic [7:0]  cmd_w   [NB][NL];
    logic [7:0]  value_w [NB][NL];
    logic [7:0]  rdata_nxt;
    logic        hit;
    logic        wr_cmd_w   [NB][NL];
    logic        wr_value_w [NB][NL];
    logic        sel_busy   [NB];
    logic [7:0]  sel_cmd    [NB];
    logic [7:0]  sel_value  [NB];

    // link number is the leading offset digit
    assign link = host_req.addr[`IRAP_LINK_MSB:`IRAP_LINK_LSB];
    assign off  = host_req.addr[7:0];

    // write strobes: one command and one value strobe per triplet
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            for (int l = 0; l < NL; l++) begin
                wr_cmd_w[b][l]   = host_req.wr && link == 3'(l)
                                   && off == CMD_OFF[b];
                wr_value_w[b][l] = host_req.wr && link == 3'(l)
                                   && off == VALUE_OFF[b];
            end
        end
    end

    for (genvar b = 0; b < NB; b++) begin : g_blk
        for (genvar l = 0; l < NL; l++) begin : g_link
            irap_chan #(
                .LAT_CYC (LAT_CYC)
            ) u_chan (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .wr_cmd   (wr_cmd_w[b][l]),
                .wr_value (wr_value_w[b][l]),
                .wdata    (host_req.wdata),
                .busy_r   (busy_w[b][l]),
                .cmd_r    (cmd_w[b][l]),
                .value_r  (value_w[b][l])
            );
        end
    end

    // registers of the addressed link, one entry per block
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            sel_busy[b]  = busy_w[b][link];
            sel_cmd[b]   = cmd_w[b][link];
            sel_value[b] = value_w[b][link];
        end
    end

    // read decode across the three triplets of the addressed link
    always_comb begin
        rdata_nxt = `IRAP_RDATA_UNMAPPED;
        hit       = 1'b0;
        for (int b = 0; b < NB; b++) begin
            if (off == STATE_OFF[b]) begin
                rdata_nxt = {7'h00, sel_busy[b]};
                hit       = 1'b1;
            end else if (off == CMD_OFF[b]) begin
                rdata_nxt = sel_cmd[b];
                hit       = 1'b1;
            end else if (off == VALUE_OFF[b]) begin
                rdata_nxt = sel_value[b];
                hit       = 1'b1;
            end
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_rdata_r <= `IRAP_RDATA_UNMAPPED;
        end else if (host_req.rd) begin
            host_rdata_r <= rdata_nxt;
        end
    end

    state_read_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (host_req.rd && off == `IRAP_RXP_STATE_OFF)
        |=> host_rdata_r == {7'h00, $past(busy_w[1][link])}
    ) else $error("state register does not show busy");

    value_read_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (host_req.rd && off == `IRAP_TXP_VALUE_OFF)
        |=> host_rdata_r == $past(value_w[0][link])
    ) else $error("value register read mismatch");

    unmapped_read_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (host_req.rd && !hit) |=> host_rdata_r == 8'h00
    ) else $error("unmapped offset did not read zero");

    link_select_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        (host_req.wr && off == `IRAP_RXS_CMD_OFF && link == 3'h7
         && !busy_w[2][7]) |=> busy_w[2][7] && !$rose(busy_w[2][0])
    ) else $error("command write reached wrong link");

    cover_busy_poll_c: cover property (
        @(posedge clk) disable iff (sys_rst)
        host_req.rd && off == `IRAP_TXP_STATE_OFF && busy_w[0][link]);
    cover_last_link_c: cover property (
        @(posedge clk) disable iff (sys_rst)
        host_req.rd && link == 3'h7 && off == `IRAP_RXS_VALUE_OFF);
    cover_refused_c: cover property (
        @(posedge clk) disable iff (sys_rst)
        busy_w[2][3] && wr_value_w[2][3]);

    // read data stands between reads
    rdata_hold_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        !host_req.rd |=> $stable(host_rdata_r)
    ) else $error("read data changed without a read");

    // every block answers its own state, command and value offsets
    for (genvar b = 0; b < NB; b++) begin : g_rd_chk
        state_bits_a: assert property (
            @(posedge clk) disable iff (sys_rst)
            (host_req.rd && off == STATE_OFF[b])
            |=> host_rdata_r == {7'h00, $past(sel_busy[b])}
        ) else $error("state register read mismatch");

        cmd_read_a: assert property (
            @(posedge clk) disable iff (sys_rst)
            (host_req.rd && off == CMD_OFF[b])
            |=> host_rdata_r == $past(sel_cmd[b])
        ) else $error("command register read mismatch");

        value_rd_a: assert property (
            @(posedge clk) disable iff (sys_rst)
            (host_req.rd && off == VALUE_OFF[b])
            |=> host_rdata_r == $past(sel_value[b])
        ) else $error("value register read mismatch");
    end

    // per triplet: access length, launch, refused writes during an access
    for (genvar b = 0; b < NB; b++) begin : g_acc_chk
        for (genvar l = 0; l < NL; l++) begin : g_link_chk
            logic [7:0] busy_cyc_r;

            always_ff @(posedge clk) begin
                if (sys_rst || !busy_w[b][l]) begin
                    busy_cyc_r <= 8'h00;
                end else if (busy_cyc_r != 8'hFF) begin
                    busy_cyc_r <= busy_cyc_r + 8'h01;
                end
            end

            busy_limit_a: assert property (
                @(posedge clk) disable iff (sys_rst)
                busy_cyc_r < 8'(MAX_WAIT)
            ) else $error("access exceeds time limit");

            cmd_refused_a: assert property (
                @(posedge clk) disable iff (sys_rst)
                (busy_w[b][l] && wr_cmd_w[b][l])
                |=> $stable(cmd_w[b][l])
            ) else $error("command accepted during access");

            value_refused_a: assert property (
                @(posedge clk) disable iff (sys_rst)
                (busy_w[b][l] && wr_value_w[b][l])
                |=> (!busy_w[b][l] || $stable(value_w[b][l]))
            ) else $error("value accepted during access");

            launch_take_a: assert property (
                @(posedge clk) disable iff (sys_rst)
                (!busy_w[b][l] && wr_cmd_w[b][l])
                |=> busy_w[b][l] && cmd_w[b][l] == $past(host_req.wdata)
            ) else $error("command write did not launch access");

            value_take_a: assert property (
                @(posedge clk) disable iff (sys_rst)
                (!busy_w[b][l] && wr_value_w[b][l])
                |=> value_w[b][l] == $past(host_req.wdata)
            ) else $error("value write not taken while idle");
        end
    end

endmodule

// >>> tb/irap_host_model.sv
// host model that drives the register port of the access port
`timescale 1ns/10ps
`include "irap_params.svh"
module irap_host_model (
    // clock
    input  wire logic           clk,
    // register port
    output irap_pkg::irap_req_t host_req,
    input  wire logic [7:0]     host_rdata_r
);
    import irap_pkg::*;
    initial begin
        host_req = '0;
    end
    // released address and data show the inverse of their last value
    task automatic reg_wr(input logic [10:0] a, input logic [7:0] v);
        @(posedge clk);
        host_req <= '{1'h0, 1'h1, a, v};
        @(posedge clk);
        host_req <= '{1'h0, 1'h0, ~a, ~v};
    endtask
    task automatic reg_rd(input logic [10:0] a, output logic [7:0] v);
        @(posedge clk);
        host_req <= '{1'h1, 1'h0, a, 8'h5A};
        @(posedge clk);
        host_req <= '{1'h0, 1'h0, ~a, 8'hA5};
        #1 v = host_rdata_r;
    endtask
    // polls at most 30 times, well inside the access limit
    task automatic wait_idle(input logic [10:0] s, output logic ok);
        logic [7:0] v;
        ok = 1'h0;
        for (int i = 0; i < 30 && !ok; i++) begin
            reg_rd(s, v);
            ok = (v[`IRAP_BUSY_BIT] === 1'h0);
        end
    endtask
    task automatic ind_wr(input logic [10:0] s, input logic [6:0] ia,
                          input logic [7:0] v, output logic ok);
        wait_idle(s, ok);
        reg_wr(s + 11'h002, v);
        reg_wr(s + 11'h001, {1'h0, ia});
        wait_idle(s, ok);
    endtask
    task automatic ind_rd(input logic [10:0] s, input logic [6:0] ia,
                          output logic [7:0] v, output logic ok);
        wait_idle(s, ok);
        reg_wr(s + 11'h001, {1'h1, ia});
        wait_idle(s, ok);
        reg_rd(s + 11'h002, v);
    endtask
endmodule

// >>> tb/irap_top_tb_top.sv
// self-checking bench of the indirect register access port
`timescale 1ns/10ps
`include "irap_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module irap_top_tb_top;
    import irap_pkg::*;
    logic                clk;
    logic                sys_rst;
    irap_req_t           host_req;
    logic [7:0]          host_rdata_r;
    logic [7:0]          d;
    logic [10:0]         s;
    logic                ok;
    int                  err_count;
    int                  num_checks;
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    irap_top #(.LAT_CYC(`IRAP_ACCESS_CYC)) i_dut (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .host_req     (host_req),
        .host_rdata_r (host_rdata_r)
    );
    irap_host_model i_host (
        .clk          (clk),
        .host_req     (host_req),
        .host_rdata_r (host_rdata_r)
    );
    function automatic logic [10:0] st(input int l, input int b);
        logic [7:0] o;
        o = (b == 0) ? `IRAP_TXP_STATE_OFF :
            (b == 1) ? `IRAP_RXP_STATE_OFF : `IRAP_RXS_STATE_OFF;
        return {l[2:0], o};
    endfunction
    function automatic logic [6:0] ia(input int l, input int b);
        return (l == 7) ? 7'h7F : 7'(l * 3 + b);
    endfunction
    function automatic logic [7:0] dat(input int l, input int b);
        return 8'(l * 32 + b * 8 + 3);
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
    initial begin
        err_count = 0;
        num_checks = 0;
        sys_rst = 1'h1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        // every register of every triplet starts at zero
        for (int l = 0; l < 8; l++)
            for (int b = 0; b < 3; b++)
                for (int r = 0; r < 3; r++) begin
                    i_host.reg_rd(st(l, b) + 11'(r), d);
                    `CHK(d, 8'h00)
                end
        // fill all triplets, then read all back to catch aliasing
        for (int p = 0; p < 2; p++)
            for (int l = 0; l < 8; l++)
                for (int b = 0; b < 3; b++) begin
                    s = st(l, b);
                    if (p == 0)
                        i_host.ind_wr(s, ia(l, b), dat(l, b), ok);
                    else
                        i_host.ind_rd(s, ia(l, b), d, ok);
                    `CHK(ok, 1'h1)
                    if (p == 1) `CHK(d, dat(l, b))
                    i_host.reg_rd(s + 11'h001, d);
                    `CHK(d, {p[0], ia(l, b)})
                end
        // busy during an access; command and value writes refused meanwhile
        s = st(3, 2);
        i_host.reg_wr(s + 11'h001, {1'h1, ia(3, 2)});
        i_host.reg_rd(s, d);
        `CHK(d, 8'h01)
        i_host.reg_wr(s + 11'h001, 8'h00);
        i_host.wait_idle(s, ok);
        `CHK(ok, 1'h1)
        i_host.reg_rd(s + 11'h002, d);
        `CHK(d, dat(3, 2))
        i_host.reg_rd(s + 11'h001, d);
        `CHK(d, {1'h1, ia(3, 2)})
        i_host.reg_wr(s + 11'h001, {1'h0, ia(3, 2)});
        i_host.reg_wr(s + 11'h002, 8'hEE);
        i_host.wait_idle(s, ok);
        i_host.reg_rd(s + 11'h002, d);
        `CHK(d, dat(3, 2))
        // unmapped offset and read-only state register
        i_host.reg_rd(11'h0CB, d);
        `CHK(d, `IRAP_RDATA_UNMAPPED)
        i_host.reg_wr(st(0, 0), 8'hFF);
        i_host.reg_rd(st(0, 0), d);
        `CHK(d, 8'h00)
        give_verdict();
    end
endmodule
